//--- pkg/lamc_defines.svh
// Offsets, field positions, reset values, level codes and step rate codes of the left mixer control bank.
// Included by the design modules; holds definitions only.
`ifndef LAMC_DEFINES_SVH
`define LAMC_DEFINES_SVH

// Register offsets on the control register port.
`define LAMC_OFS_LEFT_PAIR   8'h13
`define LAMC_OFS_RESERVED    8'h14
`define LAMC_OFS_RIGHT_PAIR  8'h15

// Field positions of the mixer registers; the power and step fields exist in the left register only.
`define LAMC_DIFF_BIT        7
`define LAMC_LEVEL_MSB       6
`define LAMC_LEVEL_LSB       3
`define LAMC_POWER_BIT       2
`define LAMC_STEP_MSB        1
`define LAMC_STEP_LSB        0

// Reset values.
`define LAMC_RST_LEFT_PAIR   8'h78
`define LAMC_RST_RESERVED    8'h78
`define LAMC_RST_RIGHT_PAIR  8'h78
`define LAMC_RST_GAIN        7'h00

// Level codes.
`define LAMC_LEVEL_MAX_GAIN  4'h8
`define LAMC_LEVEL_OPEN      4'hF
`define LAMC_ATTEN_PER_CODE  5'h03

// Soft-step rate codes.
`define LAMC_STEP_EVERY_ONE  2'h0
`define LAMC_STEP_EVERY_TWO  2'h1

`endif

//--- pkg/lamc_pkg.sv
// Types of the left mixer control bank.
// Constants live in lamc_defines.svh; this package holds the types only.
package lamc_pkg;

  // Phase of the soft-step engine between sample ticks.
  typedef enum logic [0:0]
  {
    PH_ARM = 1'b0,
    PH_GO  = 1'b1
  } lamc_phase_e;

  typedef logic [3:0] lamc_level_t;
  typedef logic [6:0] lamc_gain_t;

endpackage

//--- rtl/lamc_level_decode.sv
// Decodes one 4-bit input level code into a mixer connect flag and an attenuation.
// Purely combinational; the caller registers the results.
`timescale 1ns/100ps
`default_nettype none
`include "lamc_defines.svh"

module lamc_level_decode
(
  // Level code
  input  wire logic [3:0] level_in,
  // Decoded controls
  output logic            connect_out,
  output logic [4:0]      atten_out
);

  // Attenuation is in 0.5 dB units, so one code step of 1.5 dB counts three.
  always_comb
  begin
    connect_out = 1'b0;
    atten_out   = 5'h00;
    if (level_in <= `LAMC_LEVEL_MAX_GAIN)
    begin
      connect_out = 1'b1; // [R04]
      atten_out   = 5'(level_in * `LAMC_ATTEN_PER_CODE); // [R04]
    end
    // Code 1111 and the forbidden codes leave the input off the mixer. [R05] [R06]
  end

endmodule
`default_nettype wire

//--- rtl/lamc_soft_step.sv
// Soft-step engine: walks the record gain toward its target in 0.5 dB steps.
// Assumes a one-cycle sample tick from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "lamc_defines.svh"

module lamc_soft_step
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  // Control
  input  wire logic       tick_in,
  input  wire logic [1:0] rate_in,
  input  wire logic [6:0] target_in,
  // Gain now applied
  output logic      [6:0] gain_out
);

  lamc_pkg::lamc_phase_e phase;
  lamc_pkg::lamc_phase_e next_phase;
  logic [6:0]            gain;
  logic [6:0]            next_gain;
  logic                  step_now;

  always_comb
  begin
    next_phase = phase;
    next_gain  = gain;
    step_now   = 1'b0;
    case (rate_in)
      `LAMC_STEP_EVERY_ONE:
      begin
        step_now   = tick_in; // [R09]
        next_phase = lamc_pkg::PH_ARM;
      end
      `LAMC_STEP_EVERY_TWO:
      begin
        if (tick_in)
        begin
          case (phase)
            lamc_pkg::PH_ARM: next_phase = lamc_pkg::PH_GO;
            lamc_pkg::PH_GO:
            begin
              next_phase = lamc_pkg::PH_ARM;
              step_now   = 1'b1; // [R09]
            end
            default: next_phase = lamc_pkg::PH_ARM;
          endcase
        end
      end
      default:
      begin
        // Stepping off: the gain lands on the target at once. [R09]
        next_phase = lamc_pkg::PH_ARM;
        next_gain  = target_in;
      end
    endcase
    if (step_now)
    begin
      if (gain < target_in)
        next_gain = 7'(gain + 7'h01); // [R12]
      else if (gain > target_in)
        next_gain = 7'(gain - 7'h01); // [R12]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      phase <= lamc_pkg::PH_ARM;
      gain  <= `LAMC_RST_GAIN;
    end
    else if (ce_in)
    begin
      phase <= next_phase;
      gain  <= next_gain;
    end
  end

  assign gain_out = gain;

endmodule
`default_nettype wire

//--- rtl/lamc_top.sv
// Left record mixer control bank: two mixer registers and a fixed reserved register.
// Assumes a host-side front end on the same clock presenting single-cycle register
// strobes, and a same-clock sample tick and gain target from the record gain stage.
`timescale 1ns/100ps
`default_nettype none
`include "lamc_defines.svh"

// Overview of operation
// R01 - Left pair top bit: differential mode, reset 0
// R02 - Right pair top bit: differential mode, reset 0
// R03 - Software keeps shared pair modes consistent
// R04 - Codes 0..8 connect, 1.5 dB steps
// R05 - Left code 1111 disconnects; reset 1111
// R06 - Right code 1111 disconnects; reset 1111
// R07 - Software never writes level codes 9..14
// R08 - Bit 2 powers left channel, reset off
// R09 - Step rate: 00 every, 01 alternate, else off
// R10 - Reserved register read-only, reads 0x78
// R11 - Right register bits 2..0 read zero
// R12 - Gain moves in 0.5 dB steps to target
// R13 - Writes update all writable fields together
module lamc_top
(
  // Clock, reset and enable
  input  wire logic       MCLK_IN,
  input  wire logic       ARST_N_IN,
  input  wire logic       CE_IN,
  // Register port
  input  wire logic       REG_WR_IN,
  input  wire logic       REG_RD_IN,
  input  wire logic [7:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  output logic      [7:0] REG_RDATA_OUT,
  output logic            REG_RVALID_OUT,
  // Record gain stage
  input  wire logic       SAMPLE_TICK_IN,
  input  wire logic [6:0] GAIN_TARGET_IN,
  output logic      [6:0] LEFT_GAIN_OUT,
  // Mixer controls
  output logic            LEFT_DIFF_MODE_OUT,
  output logic            RIGHT_DIFF_MODE_OUT,
  output logic            FIRST_LEFT_INPUT_CONNECT_OUT,
  output logic      [4:0] FIRST_LEFT_INPUT_ATTEN_OUT,
  output logic            FIRST_RIGHT_INPUT_CONNECT_OUT,
  output logic      [4:0] FIRST_RIGHT_INPUT_ATTEN_OUT,
  output logic            LEFT_POWER_UP_OUT
);

  // Left pair register state.
  logic       left_diff;
  logic       left_power;
  logic [3:0] left_level;
  logic [1:0] step_rate;
  logic       next_left_diff;
  logic       next_left_power;
  logic [3:0] next_left_level;
  logic [1:0] next_step_rate;

  // Right pair register state; its low three bits have no storage.
  logic       right_diff;
  logic [3:0] right_level;
  logic       next_right_diff;
  logic [3:0] next_right_level;

  // Write strobes, one per writable register.
  logic       wr_left_pair;
  logic       wr_right_pair;

  // Read path state.
  logic [7:0] rdata;
  logic       rvalid;
  logic [7:0] next_rdata;
  logic       next_rvalid;

  // Registered mixer outputs: index 0 is the first left input, 1 the first right input.
  logic       conn_q [2];
  logic [4:0] atten_q [2];
  logic [3:0] level_sel [2];

  // Gain now applied, from the soft-step engine.
  logic [6:0] gain;

  // Address match, used by every write strobe.
  function automatic logic hit
  (
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    hit = (addr == ofs);
  endfunction

  // Mode bit of a written byte, at the same place in both mixer registers.
  function automatic logic diff_field
  (
    input logic [7:0] data
  );
    diff_field = data[`LAMC_DIFF_BIT];
  endfunction

  // Level field of a written byte, at the same place in both mixer registers.
  function automatic logic [3:0] level_field
  (
    input logic [7:0] data
  );
    level_field = data[`LAMC_LEVEL_MSB:`LAMC_LEVEL_LSB];
  endfunction

  // Byte image of the left pair register as the host reads it back.
  function automatic logic [7:0] left_image
  (
    input logic       diff,
    input logic [3:0] level,
    input logic       power,
    input logic [1:0] rate
  );
    left_image = {diff, level, power, rate};
  endfunction

  // Byte image of the right pair register; its low bits always read zero.
  function automatic logic [7:0] right_image
  (
    input logic       diff,
    input logic [3:0] level
  );
    right_image = {diff, level, 3'h0}; // [R11]
  endfunction

  // Write strobes. The reserved register and unmapped offsets get none, so a write
  // there falls away and the reserved byte can never be disturbed. [R10]
  assign wr_left_pair  = REG_WR_IN && hit(REG_ADDR_IN, `LAMC_OFS_LEFT_PAIR);
  assign wr_right_pair = REG_WR_IN && hit(REG_ADDR_IN, `LAMC_OFS_RIGHT_PAIR);

  // Left pair register: every field takes the new byte in the same cycle. [R13]
  always_comb
  begin
    next_left_diff  = left_diff;
    next_left_level = left_level;
    next_left_power = left_power;
    next_step_rate  = step_rate;
    if (wr_left_pair)
    begin
      next_left_diff  = diff_field(REG_WDATA_IN); // [R01]
      next_left_level = level_field(REG_WDATA_IN); // [R04]
      next_left_power = REG_WDATA_IN[`LAMC_POWER_BIT]; // [R08]
      next_step_rate  = REG_WDATA_IN[`LAMC_STEP_MSB:`LAMC_STEP_LSB]; // [R09]
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      left_diff  <= 1'b0; // [R01]
      left_level <= `LAMC_LEVEL_OPEN; // [R05]
      left_power <= 1'b0; // [R08]
      step_rate  <= `LAMC_STEP_EVERY_ONE; // [R09]
    end
    else if (CE_IN)
    begin
      left_diff  <= next_left_diff;
      left_level <= next_left_level;
      left_power <= next_left_power;
      step_rate  <= next_step_rate;
    end
  end

  // Right pair register: the low three bits of the written byte are dropped. [R11] [R13]
  always_comb
  begin
    next_right_diff  = right_diff;
    next_right_level = right_level;
    if (wr_right_pair)
    begin
      next_right_diff  = diff_field(REG_WDATA_IN); // [R02]
      next_right_level = level_field(REG_WDATA_IN); // [R04]
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      right_diff  <= 1'b0; // [R02]
      right_level <= `LAMC_LEVEL_OPEN; // [R06]
    end
    else if (CE_IN)
    begin
      right_diff  <= next_right_diff;
      right_level <= next_right_level;
    end
  end

  // Read path: data answers one enabled edge after the strobe; unmapped offsets read zero.
  // A read in the cycle of a write to the same register returns the old byte.
  always_comb
  begin
    next_rdata  = 8'h00;
    next_rvalid = REG_RD_IN;
    if (REG_RD_IN)
    begin
      case (REG_ADDR_IN)
        `LAMC_OFS_LEFT_PAIR:
        begin
          next_rdata = left_image(left_diff, left_level, left_power, step_rate);
        end
        `LAMC_OFS_RESERVED:
        begin
          // Fixed byte with no storage behind it.
          next_rdata = `LAMC_RST_RESERVED; // [R10]
        end
        `LAMC_OFS_RIGHT_PAIR:
        begin
          next_rdata = right_image(right_diff, right_level); // [R11]
        end
        default:
        begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end
    else if (CE_IN)
    begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Level decode for both inputs; results are registered so the mixer sees
  // glitch-free controls even while a write changes several fields.
  assign level_sel[0] = left_level;
  assign level_sel[1] = right_level;

  for (genvar i = 0; i < 2; i++)
  begin : g_level
    logic       dec_conn;
    logic [4:0] dec_atten;
    logic       next_conn;
    logic [4:0] next_atten;

    lamc_level_decode u_dec
    (
      .level_in    (level_sel[i]),
      .connect_out (dec_conn),
      .atten_out   (dec_atten)
    );

    // Reserved codes decode as open, so a stray code never patches an input in.
    always_comb
    begin
      next_conn  = dec_conn; // [R04]
      next_atten = dec_atten;
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
    begin
      if (!ARST_N_IN)
      begin
        conn_q[i]  <= 1'b0; // [R05] [R06]
        atten_q[i] <= 5'h00;
      end
      else if (CE_IN)
      begin
        conn_q[i]  <= next_conn; // [R04]
        atten_q[i] <= next_atten;
      end
    end
  end

  // Soft stepping of the left record gain. It runs whether or not the channel is powered up,
  // so the gain may still be stepping when the channel is powered up.
  lamc_soft_step u_step
  (
    .clk_in    (MCLK_IN),
    .rst_n_in  (ARST_N_IN),
    .ce_in     (CE_IN),
    .tick_in   (SAMPLE_TICK_IN),
    .rate_in   (step_rate), // [R09]
    .target_in (GAIN_TARGET_IN), // [R12]
    .gain_out  (gain)
  );

  // Register port.
  assign REG_RDATA_OUT                 = rdata;
  assign REG_RVALID_OUT                = rvalid;

  // Record gain stage.
  assign LEFT_GAIN_OUT                 = gain;

  // Mixer controls.
  assign LEFT_DIFF_MODE_OUT            = left_diff;
  assign RIGHT_DIFF_MODE_OUT           = right_diff;
  assign FIRST_LEFT_INPUT_CONNECT_OUT  = conn_q[0];
  assign FIRST_LEFT_INPUT_ATTEN_OUT    = atten_q[0];
  assign FIRST_RIGHT_INPUT_CONNECT_OUT = conn_q[1];
  assign FIRST_RIGHT_INPUT_ATTEN_OUT   = atten_q[1];
  assign LEFT_POWER_UP_OUT             = left_power;

endmodule
`default_nettype wire

//--- bench/lamc_checker.sv
// Concurrent checks on the ports of the left mixer control bank.
// Assumes binding to lamc_top; all ports share the one clock and reset.
`timescale 1ns/100ps
`default_nettype none
module lamc_checker
(
  // Clock, reset and enable
  input wire logic       MCLK_IN,
  input wire logic       ARST_N_IN,
  input wire logic       CE_IN,
  // Register port
  input wire logic       REG_WR_IN,
  input wire logic       REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic       REG_RVALID_OUT,
  // Record gain stage
  input wire logic       SAMPLE_TICK_IN,
  input wire logic [6:0] GAIN_TARGET_IN,
  input wire logic [6:0] LEFT_GAIN_OUT,
  // Mixer controls
  input wire logic       LEFT_DIFF_MODE_OUT,
  input wire logic       RIGHT_DIFF_MODE_OUT,
  input wire logic       FIRST_LEFT_INPUT_CONNECT_OUT,
  input wire logic [4:0] FIRST_LEFT_INPUT_ATTEN_OUT,
  input wire logic       FIRST_RIGHT_INPUT_CONNECT_OUT,
  input wire logic [4:0] FIRST_RIGHT_INPUT_ATTEN_OUT,
  input wire logic       LEFT_POWER_UP_OUT
);
  // The step rate is not visible at the ports, so it is shadowed from the writes.
  logic [1:0] rate;
  wire logic wl = CE_IN && REG_WR_IN && REG_ADDR_IN == 8'h13;
  wire logic wr = CE_IN && REG_WR_IN && REG_ADDR_IN == 8'h15;
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN)
      rate <= 2'h0;
    else if (wl)
      rate <= REG_WDATA_IN[1:0];
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  property p_diff_l; wl |=> LEFT_DIFF_MODE_OUT == $past(REG_WDATA_IN[7]); endproperty
  a_diff_l: assert property (p_diff_l) else $error("left mode wrong");
  property p_diff_r; wr |=> RIGHT_DIFF_MODE_OUT == $past(REG_WDATA_IN[7]); endproperty
  a_diff_r: assert property (p_diff_r) else $error("right mode wrong");
  property p_pwr; wl |=> LEFT_POWER_UP_OUT == $past(REG_WDATA_IN[2]); endproperty
  a_pwr: assert property (p_pwr) else $error("power bit wrong");
  property p_conn;
    wl && REG_WDATA_IN[6:3] <= 4'h8 ##1 CE_IN && !wl |=> FIRST_LEFT_INPUT_CONNECT_OUT
      && FIRST_LEFT_INPUT_ATTEN_OUT == $past(REG_WDATA_IN[6:3], 2) * 5'h03;
  endproperty
  a_conn: assert property (p_conn) else $error("level decode wrong");
  property p_open;
    wr && REG_WDATA_IN[6:3] == 4'hF ##1 CE_IN && !wr |=>
      !FIRST_RIGHT_INPUT_CONNECT_OUT && FIRST_RIGHT_INPUT_ATTEN_OUT == 5'h00;
  endproperty
  a_open: assert property (p_open) else $error("right input not open");
  property p_rsvd;
    CE_IN && REG_RD_IN && REG_ADDR_IN == 8'h14 |=> REG_RVALID_OUT && REG_RDATA_OUT == 8'h78;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read wrong");
  property p_rbits;
    CE_IN && REG_RD_IN && REG_ADDR_IN == 8'h15 |=> REG_RVALID_OUT && REG_RDATA_OUT[2:0] == 3'h0;
  endproperty
  a_rbits: assert property (p_rbits) else $error("right low bits set");
  property p_step;
    CE_IN && SAMPLE_TICK_IN && rate == 2'h0 && LEFT_GAIN_OUT < GAIN_TARGET_IN
      |=> LEFT_GAIN_OUT == $past(LEFT_GAIN_OUT) + 7'h01;
  endproperty
  a_step: assert property (p_step) else $error("gain step wrong");
  property p_jump; CE_IN && rate[1] |=> LEFT_GAIN_OUT == $past(GAIN_TARGET_IN); endproperty
  a_jump: assert property (p_jump) else $error("gain not direct");
  property p_hold; CE_IN && !SAMPLE_TICK_IN && !rate[1] |=> $stable(LEFT_GAIN_OUT); endproperty
  a_hold: assert property (p_hold) else $error("gain moved off tick");
  c_wl: cover property (wl);
  c_half: cover property (rate == 2'h1 && SAMPLE_TICK_IN);
  c_read: cover property (REG_RVALID_OUT);
endmodule
`default_nettype wire

//--- bench/lamc_top_test.sv
// Self-checking bench for the left mixer control bank.
// Drives all ports itself; the checker is bound at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module lamc_top_test;
  logic mclk, arst_n, ce, wr_s, rd_s, tick, rv, dl, dr, cl, cr, pw;
  logic [7:0] addr, wdata, rdata, d, e;
  logic [6:0] target, gain, t;
  logic [4:0] al, ar;
  logic [3:0] c1, c2;
  int err_total, total_checks, cycles;
  lamc_top DUT (.MCLK_IN(mclk), .ARST_N_IN(arst_n), .CE_IN(ce), .REG_WR_IN(wr_s),
    .REG_RD_IN(rd_s), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rv), .SAMPLE_TICK_IN(tick), .GAIN_TARGET_IN(target),
    .LEFT_GAIN_OUT(gain), .LEFT_DIFF_MODE_OUT(dl), .RIGHT_DIFF_MODE_OUT(dr),
    .FIRST_LEFT_INPUT_CONNECT_OUT(cl), .FIRST_LEFT_INPUT_ATTEN_OUT(al),
    .FIRST_RIGHT_INPUT_CONNECT_OUT(cr), .FIRST_RIGHT_INPUT_ATTEN_OUT(ar),
    .LEFT_POWER_UP_OUT(pw));
  function automatic logic [7:0] exp_dec(input logic [3:0] c);
    return (c <= 4'h8) ? {2'h0, 1'b1, 5'(c) * 5'h03} : 8'h00;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk) #1;
    wr_s = 1'b1;
    addr = a;
    wdata = v;
    @(posedge mclk) #1;
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) #1;
    rd_s = 1'b1;
    addr = a;
    @(posedge mclk) #1;
    rd_s = 1'b0;
    chk({7'h00, rv}, 8'h01);
    chk(rdata, exp);
  endtask
  // Ticks are spaced at random so the stepping cannot lean on a fixed cadence.
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge mclk) #1;
      tick = 1'b1;
      @(posedge mclk) #1;
      tick = 1'b0;
      repeat ($urandom_range(3, 0)) @(posedge mclk);
    end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  initial
  begin
    {arst_n, wr_s, rd_s, tick, addr, wdata, target} = '0;
    ce = 1'b1;
    void'($urandom(43655));
    repeat (10) @(posedge mclk);
    #1 arst_n = 1'b1;
    chk({dl, dr, pw, cl, cr, 3'h0}, 8'h00);
    chk({3'h0, al}, 8'h00);
    chk({3'h0, ar}, 8'h00);
    chk({1'b0, gain}, 8'h00);
    rd(8'h13, 8'h78);
    rd(8'h14, 8'h78);
    rd(8'h15, 8'h78);
    for (int i = 0; i < 10; i++)
    begin
      c1 = (i == 9) ? 4'hF : 4'(i);
      c2 = (i == 9) ? 4'hF : 4'(8 - i);
      d = 8'($urandom);
      e = 8'($urandom);
      d[6:3] = c1;
      e[6:3] = c2;
      e[2:0] = 3'h0;
      // The right record channel lies outside this block, so no pair feeds both.
      wr(8'h13, d);
      wr(8'h15, e);
      @(posedge mclk) #1;
      chk({dl, pw, dr, 5'h00}, {d[7], d[2], e[7], 5'h00});
      chk({2'h0, cl, al}, exp_dec(c1));
      chk({2'h0, cr, ar}, exp_dec(c2));
      rd(8'h13, d);
      rd(8'h15, {e[7:3], 3'h0});
    end
    // The reserved byte is never written; a neighbour write must leave it alone.
    wr(8'h15, 8'h78);
    rd(8'h14, 8'h78);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    ce = 1'b0;
    wr(8'h13, 8'h00);
    ce = 1'b1;
    rd(8'h13, d);
    t = 7'($urandom_range(20, 8));
    wr(8'h13, 8'h7C);
    target = t;
    pulse(5);
    chk({1'b0, gain}, 8'h05);
    wr(8'h13, 8'h7D);
    pulse(6);
    chk({1'b0, gain}, 8'h08);
    wr(8'h13, 8'h7E);
    @(posedge mclk) #1;
    chk({1'b0, gain}, {1'b0, t});
    wr(8'h13, 8'h7C);
    target = 7'h00;
    pulse(3);
    chk({1'b0, gain}, {1'b0, t - 7'h03});
    close_out();
  end
endmodule
bind lamc_top lamc_checker u_chk (.*);
`default_nettype wire
